// >>> rtl/msir_router.sv
// Interrupt router: enable, route, polarity, drive style, sleep wake.
// Source flags are levels from the detectors, held until they clear them.
`timescale 1ns/1ns
module msir_router
    import msir_pkg::*;
(
    input wire logic sys_clk, // 25 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic sw_reset, // Software reset pulse
    input wire logic reg_wr, // Register write strobe
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, registered
    input wire logic [7:0] src_flags, // Detector flags, levels
    input wire logic in_sleep, // Device is in auto-sleep
    output logic wake_req, // Request to leave sleep
    output logic irq_first_o, // First pin output level
    output logic irq_first_oe, // First pin drive enable
    output logic irq_second_o, // Second pin output level
    output logic irq_second_oe // Second pin drive enable
);
    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        logic [7:0] ctrl; // Sleep-wake and pin control
        logic [7:0] en; // Enable map
        logic [7:0] route; // Pin routing
        logic aslp_ev; // Sleep change event, sticky
        logic sleep_prev; // Last sleep level
        logic [7:0] rdata;
        logic wake;
        logic p1_o, p1_oe, p2_o, p2_oe;
    } msir_state_t;
    msir_state_t s_q, s_d;
    logic [7:0] act; // Active flags incl. sleep change
    logic [7:0] live; // Enabled, and allowed in sleep
    logic [7:0] wmask; // Sources that may wake
    logic a1, a2; // Pin asserted

    // Next-state logic
    always_comb begin
        s_d = s_q;
        // Each sleep edge raises the sleep change event, except in a cycle with a software reset
        if (s_q.sleep_prev != in_sleep) begin
            s_d.aslp_ev = 1'b1; // RQ14
        end
        s_d.sleep_prev = in_sleep;
        act = src_flags & MSIR_SRC_MASK;
        act[MSIR_B_ASLP] = s_q.aslp_ev;
        wmask = 8'h00;
        wmask[MSIR_B_TRANS] = s_q.ctrl[MSIR_B_WTRANS]; // RQ1
        wmask[MSIR_B_ORIENT] = s_q.ctrl[MSIR_B_WORIENT]; // RQ2
        wmask[MSIR_B_PULSE] = s_q.ctrl[MSIR_B_WPULSE]; // RQ3
        wmask[MSIR_B_FFMT] = s_q.ctrl[MSIR_B_WFFMT]; // RQ4
        // Bypassed functions stay silent while asleep
        live = act & s_q.en & (in_sleep ? (wmask | 8'h81) : 8'hff); // RQ8
        s_d.wake = in_sleep && |(act & s_q.en & wmask); // RQ16
        a1 = |(live & s_q.route); // RQ10 RQ12 RQ17
        a2 = |(live & ~s_q.route); // RQ10 RQ12 RQ17
        // Level by polarity; open drain drives only when asserted
        s_d.p1_o = a1 ~^ s_q.ctrl[MSIR_B_POL]; // RQ5
        s_d.p2_o = a2 ~^ s_q.ctrl[MSIR_B_POL]; // RQ5
        s_d.p1_oe = s_q.ctrl[MSIR_B_OD] ? a1 : 1'b1; // RQ6
        s_d.p2_oe = s_q.ctrl[MSIR_B_OD] ? a2 : 1'b1; // RQ6
        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                MSIR_OFS_CTRL: s_d.ctrl = reg_wdata & MSIR_CTRL_MASK;
                MSIR_OFS_EN: s_d.en = reg_wdata & MSIR_SRC_MASK; // RQ9
                MSIR_OFS_ROUTE: s_d.route = reg_wdata & MSIR_SRC_MASK; // RQ11
                default: ;
            endcase
        end
        // Reading status clears the sleep event; a new edge wins
        unique case (reg_addr)
            MSIR_OFS_SRC: s_d.rdata = act; // RQ13
            MSIR_OFS_CTRL: s_d.rdata = s_q.ctrl;
            MSIR_OFS_EN: s_d.rdata = s_q.en;
            MSIR_OFS_ROUTE: s_d.rdata = s_q.route;
            default: s_d.rdata = 8'h00;
        endcase
        if (!reg_wr && reg_addr == MSIR_OFS_SRC
            && s_q.sleep_prev == in_sleep) begin
            s_d.aslp_ev = 1'b0;
        end
        // Software reset restores defaults
        if (sw_reset) begin
            s_d.ctrl = MSIR_CTRL_RST; // RQ15
            s_d.en = MSIR_EN_RST; // RQ15
            s_d.route = MSIR_ROUTE_RST; // RQ15
            s_d.aslp_ev = 1'b0;
        end
    end

    // State register; pins idle high (inactive, low polarity)
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.p1_o <= 1'b1;
            s_q.p2_o <= 1'b1;
            s_q.p1_oe <= 1'b1;
            s_q.p2_oe <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign wake_req = s_q.wake;
    assign irq_first_o = s_q.p1_o;
    assign irq_first_oe = s_q.p1_oe;
    assign irq_second_o = s_q.p2_o;
    assign irq_second_oe = s_q.p2_oe;

    // ****************************************************
    // Checks
    // ****************************************************
    property p_dis_quiet;
        @(posedge sys_clk) disable iff (rst)
        (s_q.en == 8'h00 && !reg_wr && !sw_reset)
            |=> (a1 == 1'b0 && a2 == 1'b0);
    endproperty
    a_dis_quiet: assert property (p_dis_quiet) else $error("disabled irq"); // RQ8
    property p_pol;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> (irq_first_o == ($past(a1) ~^ $past(s_q.ctrl[MSIR_B_POL])));
    endproperty
    a_pol: assert property (p_pol) else $error("polarity wrong"); // RQ5
    property p_od;
        @(posedge sys_clk) disable iff (rst)
        (s_q.ctrl[MSIR_B_OD] && !a2) |=> !irq_second_oe;
    endproperty
    a_od: assert property (p_od) else $error("open drain drove"); // RQ6
    property p_pp;
        @(posedge sys_clk) disable iff (rst)
        !s_q.ctrl[MSIR_B_OD] |=> irq_first_oe;
    endproperty
    a_pp: assert property (p_pp) else $error("push-pull released"); // RQ6
    property p_slp;
        @(posedge sys_clk) disable iff (rst)
        // Software reset in the same cycle clears the event on purpose
        (s_q.sleep_prev != in_sleep && !sw_reset) |=> s_q.aslp_ev;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep edge lost"); // RQ14
    property p_wake;
        @(posedge sys_clk) disable iff (rst)
        (in_sleep && (s_q.ctrl & 8'h78) == 8'h00) |=> !wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("bad wake"); // RQ16
    property p_swr;
        @(posedge sys_clk) disable iff (rst)
        sw_reset |=> (s_q.ctrl == 8'h00 && s_q.en == 8'h00
            && s_q.route == 8'h00);
    endproperty
    a_swr: assert property (p_swr) else $error("soft reset failed"); // RQ15
    property p_route;
        @(posedge sys_clk) disable iff (rst)
        (s_q.route == 8'h00 && !reg_wr && !sw_reset) |=> !a1;
    endproperty
    a_route: assert property (p_route) else $error("routing wrong"); // RQ10
    property p_rsv;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |-> (s_q.en[6] == 1'b0 && s_q.en[1] == 1'b0);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set"); // RQ9

    // ****************************************************
    // Wake, bypass and hold checks
    // ****************************************************
    // Asleep with a wake-enabled, enabled source active
    sequence s_wake_cause;
        in_sleep && |(act & s_q.en & wmask);
    endsequence
    // The registered request follows one edge later
    sequence s_wake_seen;
        wake_req;
    endsequence
    property p_wake_set;
        @(posedge sys_clk) disable iff (rst)
        s_wake_cause |=> s_wake_seen;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake missed"); // RQ1
    // Orientation alone, not allowed to wake, stays off both pins
    property p_orient_bypass;
        @(posedge sys_clk) disable iff (rst)
        (in_sleep && !s_q.ctrl[MSIR_B_WORIENT] && s_q.en == 8'h10)
            |-> !(a1 || a2);
    endproperty
    a_orient_bypass: assert property (p_orient_bypass) // RQ2
        else $error("orientation not bypassed");
    // Pulse alone, not allowed to wake, stays off both pins
    property p_pulse_bypass;
        @(posedge sys_clk) disable iff (rst)
        (in_sleep && !s_q.ctrl[MSIR_B_WPULSE] && s_q.en == 8'h08)
            |-> !(a1 || a2);
    endproperty
    a_pulse_bypass: assert property (p_pulse_bypass) // RQ3
        else $error("pulse not bypassed");
    // Any routed live source drives the first pin to its active level
    property p_first_hold;
        @(posedge sys_clk) disable iff (rst)
        |(live & s_q.route) |=> (irq_first_o == $past(s_q.ctrl[MSIR_B_POL]));
    endproperty
    a_first_hold: assert property (p_first_hold) // RQ12
        else $error("first pin dropped");
    // Same for the second pin, which takes the unrouted sources
    property p_second_hold;
        @(posedge sys_clk) disable iff (rst)
        |(live & ~s_q.route)
            |=> (irq_second_o == $past(s_q.ctrl[MSIR_B_POL]));
    endproperty
    a_second_hold: assert property (p_second_hold) // RQ17
        else $error("second pin dropped");
endmodule // msir_router

// >>> rtl/msir_pkg.sv
// Constants shared by the motion sensor interrupt router.
// Assumes an 8-bit register port driven by the device's serial front end.
// Function
// RQ1: Transient wake bit gates transient wakeups in sleep
// RQ2: Orientation wake bit gates orientation wakeups
// RQ3: Pulse wake bit gates pulse wakeups
// RQ4: Motion wake bit gates wakeups; wakes reset 0
// RQ5: Polarity bit picks pin active level
// RQ6: Drive bit picks push-pull or open drain
// RQ7: Board uses open drain for shared lines
// RQ8: Disabled source never asserts any pin
// RQ9: Enable map bit positions, all reset zero
// RQ10: Routing bit one first pin, zero second
// RQ11: Routing uses same positions as enable map
// RQ12: Pin asserts when any routed source active
// RQ13: Host reads source status to identify cause
// RQ14: Each sleep entry and exit raises event; a software reset in the same cycle clears it
// RQ15: Software reset restores all control registers
// RQ16: In sleep only wake-enabled events wake
// RQ17: Pin holds while any routed flag set
package msir_pkg;
    // ****************************************************
    // Register offsets
    // ****************************************************
    localparam logic [7:0] MSIR_OFS_SRC = 8'h0c; // Source status
    localparam logic [7:0] MSIR_OFS_CTRL = 8'h2c; // Sleep-wake and pin ctrl
    localparam logic [7:0] MSIR_OFS_EN = 8'h2d; // Enable map
    localparam logic [7:0] MSIR_OFS_ROUTE = 8'h2e; // Pin routing
    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int MSIR_B_ASLP = 7; // Sleep change source
    localparam int MSIR_B_TRANS = 5; // Transient source
    localparam int MSIR_B_ORIENT = 4; // Orientation source
    localparam int MSIR_B_PULSE = 3; // Pulse source
    localparam int MSIR_B_FFMT = 2; // Freefall/motion source
    localparam int MSIR_B_DRDY = 0; // Sample ready source
    localparam int MSIR_B_WTRANS = 6; // Wake bits in control reg
    localparam int MSIR_B_WORIENT = 5;
    localparam int MSIR_B_WPULSE = 4;
    localparam int MSIR_B_WFFMT = 3;
    localparam int MSIR_B_POL = 1; // Active level
    localparam int MSIR_B_OD = 0; // Drive style
    // ****************************************************
    // Masks and reset values
    // ****************************************************
    localparam logic [7:0] MSIR_SRC_MASK = 8'hbd; // Bits 6 and 1 zero
    localparam logic [7:0] MSIR_CTRL_MASK = 8'h7b; // Writable ctrl bits
    localparam logic [7:0] MSIR_CTRL_RST = 8'h00;
    localparam logic [7:0] MSIR_EN_RST = 8'h00;
    localparam logic [7:0] MSIR_ROUTE_RST = 8'h00;
endpackage

// >>> testbench/msir_host_model.sv
// Host side of the two interrupt lines: resolves each wire level.
// Assumes a pull resistor holds a released line at its idle level.
`timescale 1ns/1ns
module msir_host_model (
    input wire logic pol, // Active level the host expects
    input wire logic f_o, // First pin level
    input wire logic f_oe, // First pin drive enable
    input wire logic s_o, // Second pin level
    input wire logic s_oe, // Second pin drive enable
    output logic line_first, // Resolved first line
    output logic line_second // Resolved second line
);
    // Released line rests idle, so lines may be shared
    assign line_first = f_oe ? f_o : ~pol;
    assign line_second = s_oe ? s_o : ~pol;
endmodule // msir_host_model

// >>> testbench/test_motion_sensor_interrupt_router.sv
// Self-checking bench for the interrupt router.
// Assumes the host model resolves the pins; one 25 MHz clock.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_motion_sensor_interrupt_router;
    import msir_pkg::*;
    logic sys_clk = 0, rst = 1, sw_reset = 0, reg_wr = 0, in_sleep = 0;
    logic pol = 0; // Level the host expects
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, src_flags = 8'h00;
    logic [7:0] reg_rdata, rd;
    logic wake_req, f_o, f_oe, s_o, s_oe, line_first, line_second;
    int bad_count = 0, compares = 0, cyc = 0;
    int srcs[5] = '{5, 4, 3, 2, 0}; // Detector source positions
    msir_router dut (.sys_clk(sys_clk), .rst(rst), .sw_reset(sw_reset),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .src_flags(src_flags), .in_sleep(in_sleep),
        .wake_req(wake_req), .irq_first_o(f_o), .irq_first_oe(f_oe),
        .irq_second_o(s_o), .irq_second_oe(s_oe));
    msir_host_model host (.pol(pol), .f_o(f_o), .f_oe(f_oe), .s_o(s_o),
        .s_oe(s_oe), .line_first(line_first), .line_second(line_second));
    initial forever #20 sys_clk = ~sys_clk;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0; reg_addr <= 8'h00;
    endtask
    // Read answer lands one edge after the address is seen
    task automatic rdc(input logic [7:0] a, e);
        @(posedge sys_clk); reg_addr <= a;
        @(posedge sys_clk); #1; rd = reg_rdata;
        `CHK(rd, e)
        // Park the address so a live status read cannot eat later events
        @(posedge sys_clk); reg_addr <= 8'h00;
    endtask
    task automatic settle(); repeat (3) @(posedge sys_clk); #1; endtask
    task automatic pins(input logic f, s);
        settle();
        `CHK({line_first, line_second}, {f ? pol : ~pol, s ? pol : ~pol})
    endtask
    task automatic flags(input logic [7:0] v);
        @(posedge sys_clk); src_flags <= v;
    endtask
    task automatic t_reset();
        rdc(MSIR_OFS_CTRL, 8'h00);
        rdc(MSIR_OFS_EN, 8'h00); rdc(MSIR_OFS_ROUTE, 8'h00);
        pins(0, 0);
        `CHK({f_oe, s_oe}, 2'b11)
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr(MSIR_OFS_CTRL, 8'hff); wr(MSIR_OFS_EN, 8'hff);
        wr(MSIR_OFS_ROUTE, 8'hff); wr(8'h30, 8'hff);
        rdc(MSIR_OFS_CTRL, 8'h7b); rdc(8'h30, 8'h00);
        rdc(MSIR_OFS_EN, 8'hbd); rdc(MSIR_OFS_ROUTE, 8'hbd);
        wr(MSIR_OFS_CTRL, 0); wr(MSIR_OFS_EN, 0); wr(MSIR_OFS_ROUTE, 0);
        $display("test registers done");
    endtask
    task automatic t_route();
        foreach (srcs[i]) begin
            flags(8'h01 << srcs[i]); pins(0, 0);
            wr(MSIR_OFS_EN, 8'h01 << srcs[i]); pins(0, 1);
            wr(MSIR_OFS_ROUTE, 8'h01 << srcs[i]); pins(1, 0);
            wr(MSIR_OFS_ROUTE, 0); wr(MSIR_OFS_EN, 0);
        end
        wr(MSIR_OFS_EN, 8'h30); wr(MSIR_OFS_ROUTE, 8'h10);
        flags(8'h30); pins(1, 1);
        rdc(MSIR_OFS_SRC, 8'h30);
        wr(MSIR_OFS_ROUTE, 8'h30); flags(8'h10); pins(1, 0);
        flags(8'h00); pins(0, 0);
        $display("test routing done");
    endtask
    task automatic t_pol();
        wr(MSIR_OFS_CTRL, 8'h03); flags(8'h20); pol <= 1'b1;
        pins(1, 0);
        `CHK({f_o, f_oe, s_oe}, 3'b110)
        wr(MSIR_OFS_CTRL, 0); wr(MSIR_OFS_EN, 0); flags(0); pol <= 1'b0;
        $display("test polarity done");
    endtask
    task automatic t_sleep();
        wr(MSIR_OFS_EN, 8'h80);
        repeat (2) begin
            @(posedge sys_clk); in_sleep <= ~in_sleep;
            pins(0, 1);
            rdc(MSIR_OFS_SRC, 8'h80); rdc(MSIR_OFS_SRC, 8'h00);
        end
        wr(MSIR_OFS_EN, 0);
        $display("test sleep change done");
    endtask
    task automatic t_wake();
        @(posedge sys_clk); in_sleep <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(MSIR_OFS_EN, 8'h01 << srcs[i]); flags(8'h01 << srcs[i]);
            wr(MSIR_OFS_CTRL, 0); settle();
            `CHK(wake_req, 1'b0)
            wr(MSIR_OFS_CTRL, 8'h02 << srcs[i]); settle();
            `CHK(wake_req, 1'b1)
        end
        flags(0); @(posedge sys_clk); in_sleep <= 1'b0;
        $display("test wake done");
    endtask
    task automatic t_swr();
        wr(MSIR_OFS_CTRL, 8'h7b); wr(MSIR_OFS_EN, 8'hbd);
        wr(MSIR_OFS_ROUTE, 8'hbd);
        @(posedge sys_clk); sw_reset <= 1'b1;
        @(posedge sys_clk); sw_reset <= 1'b0;
        rdc(MSIR_OFS_CTRL, 0); rdc(MSIR_OFS_EN, 0);
        rdc(MSIR_OFS_ROUTE, 0);
        $display("test software reset done");
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset(); t_regs(); t_route(); t_pol(); t_sleep(); t_wake(); t_swr();
        print_verdict();
    end
endmodule // test_motion_sensor_interrupt_router
